//--- acmp_regs.svh
`ifndef ACMP_REGS_SVH
`define ACMP_REGS_SVH
// ----------------------------------------------------------------
// register offsets, byte addresses from the block base
// ----------------------------------------------------------------
`define ACMP_MIS_OFS 12'h000
`define ACMP_RIS_OFS 12'h004
`define ACMP_INTEN_OFS 12'h008
`define ACMP_REFCTL_OFS 12'h010
`define ACMP_STAT0_OFS 12'h020
`define ACMP_CTL0_OFS 12'h024
`define ACMP_STAT1_OFS 12'h040
`define ACMP_CTL1_OFS 12'h044
`define ACMP_STAT2_OFS 12'h060
`define ACMP_CTL2_OFS 12'h064
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ACMP_RST_CTL 12'h000
`define ACMP_RST_REF 10'h000
`define ACMP_RST_BITS 3'h0
`define ACMP_RST_WORD 32'h0000_0000
`define ACMP_RST_CONN 3'h7
// ----------------------------------------------------------------
// comparator control fields
// ----------------------------------------------------------------
`define ACMP_CTL_W 12
`define ACMP_CTL_INV 1
`define ACMP_CTL_SENSE_LO 2
`define ACMP_CTL_SENSE_HI 3
`define ACMP_CTL_LEVEL 4
`define ACMP_CTL_SRC_LO 9
`define ACMP_CTL_SRC_HI 10
`define ACMP_CTL_PIN_EN 11
// ----------------------------------------------------------------
// reference ladder control fields and figures
// ----------------------------------------------------------------
`define ACMP_REF_W 10
`define ACMP_REF_TAP_LO 0
`define ACMP_REF_TAP_HI 3
`define ACMP_REF_RNG 8
`define ACMP_REF_EN 9
`define ACMP_LADDER_LOW_UNITS 6'h20
`define ACMP_LADDER_HIGH_UNITS 6'h18
`define ACMP_LADDER_OFFSET 6'h08
`define ACMP_TAP_GROUND 6'h00
// ----------------------------------------------------------------
// positive source codes
// ----------------------------------------------------------------
`define ACMP_SRC_OWN 2'h0
`define ACMP_SRC_SHARED 2'h1
`define ACMP_SRC_VREF 2'h2
`define ACMP_SRC_RSVD 2'h3
`endif

//--- acmp_pkg.sv
package acmp_pkg;
    // interrupt sense modes, in control field code order
    typedef enum logic [1:0]
    {
        ACMP_SENSE_LEVEL,
        ACMP_SENSE_FALL,
        ACMP_SENSE_RISE,
        ACMP_SENSE_BOTH
    } acmp_sense_type;
    // positive input source select code
    typedef logic [1:0] acmp_src_type;
endpackage

//--- acmp_ctrl.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "acmp_regs.svh"
module acmp_ctrl
    import acmp_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // comparator results, asynchronous to i_clk
    input wire logic [2:0] i_compare_result,
    // positive input mux controls
    output logic [1:0] o_comp0_positive_source_select,
    output logic [1:0] o_comp1_positive_source_select,
    output logic [1:0] o_comp2_positive_source_select,
    output logic [2:0] o_positive_connect,
    // reference ladder controls
    output logic o_ladder_enable,
    output logic o_ladder_range_select,
    output logic [5:0] o_ladder_total_units,
    output logic [5:0] o_ladder_tap_pos,
    // comparator 0 output pin, shared with comp1 positive pin
    output logic o_comp0_output_pin_o,
    output logic o_comp0_output_pin_oe,
    // controller interrupt
    output logic o_irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [`ACMP_CTL_W-1:0] ctl_r [3]; // per comparator control
    logic [`ACMP_CTL_W-1:0] ctl_nxt [3];
    logic [`ACMP_REF_W-1:0] ref_r; // ladder control
    logic [`ACMP_REF_W-1:0] ref_nxt;
    logic [2:0] inten_r; // interrupt enables
    logic [2:0] inten_nxt;
    logic [2:0] raw_r; // sticky raw status
    logic [2:0] raw_nxt;
    logic [2:0] sync1_r; // first sync stage, read by sync2 only
    logic [2:0] sync2_r; // second sync stage
    logic [2:0] res_r; // result after polarity
    logic [2:0] res_nxt;
    logic [2:0] prev_r; // result one cycle back, for edges
    logic [2:0] conn_r; // source legal per comparator
    logic [2:0] conn_nxt;
    logic [5:0] tap_r; // ladder tap position
    logic [5:0] tap_nxt;
    logic [5:0] units_r; // ladder total units
    logic [5:0] units_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    logic access; // apb access phase
    logic done; // transfer completes this edge
    logic hit; // address is mapped
    logic [31:0] rdata; // selected read word
    logic [2:0] ev; // interrupt event per comparator
    logic [2:0] clr; // write one to clear per comparator

    // a source code is legal unless reserved for that comparator
    function automatic logic src_legal(input int idx,
                                       input acmp_src_type s);
        logic ok;
        ok = 1'b1;
        if (idx == 0)
        begin
            ok = (s != `ACMP_SRC_RSVD);
        end
        else
        begin
            // codes 10 and 11 carry no input on comp1 and comp2
            ok = (s == `ACMP_SRC_OWN) || (s == `ACMP_SRC_SHARED);
        end
        return ok;
    endfunction

    // ------------------------------------------------------------
    // event detection, kept apart from the pin path
    // ------------------------------------------------------------
    // one sense decoder per comparator; its only output is ev
    for (genvar g = 0; g < 3; g++)
    begin : g_sense
        acmp_sense_type sense;
        always_comb
        begin
            sense = acmp_sense_type'(
                ctl_r[g][`ACMP_CTL_SENSE_HI:`ACMP_CTL_SENSE_LO]);
            case (sense)
                ACMP_SENSE_LEVEL:
                    ev[g] = res_r[g] == ctl_r[g][`ACMP_CTL_LEVEL];
                ACMP_SENSE_FALL:
                    ev[g] = prev_r[g] & ~res_r[g];
                ACMP_SENSE_RISE:
                    ev[g] = ~prev_r[g] & res_r[g];
                default:
                    ev[g] = prev_r[g] ^ res_r[g];
            endcase
            // a reserved source never interrupts
            if (!conn_r[g])
            begin
                ev[g] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // next state: bus, registers, ladder, status
    // ------------------------------------------------------------
    // one wait state per transfer so read data comes from a flop
    always_comb
    begin
        ctl_nxt = ctl_r;
        ref_nxt = ref_r;
        inten_nxt = inten_r;
        access = i_psel & i_penable;
        done = access & pready_r;
        pready_nxt = access & ~pready_r;
        hit = 1'b1;
        rdata = `ACMP_RST_WORD;
        clr = `ACMP_RST_BITS;
        // address decode, offsets from the block base
        if (i_paddr == `ACMP_MIS_OFS)
        begin
            rdata = {29'h0, raw_r & inten_r};
            if (done && i_pwrite)
            begin
                clr = i_pwdata[2:0];
            end
        end
        else if (i_paddr == `ACMP_RIS_OFS)
        begin
            rdata = {29'h0, raw_r};
        end
        else if (i_paddr == `ACMP_INTEN_OFS)
        begin
            rdata = {29'h0, inten_r};
            if (done && i_pwrite)
            begin
                inten_nxt = i_pwdata[2:0];
            end
        end
        else if (i_paddr == `ACMP_REFCTL_OFS)
        begin
            rdata = {22'h0, ref_r};
            if (done && i_pwrite)
            begin
                ref_nxt = i_pwdata[`ACMP_REF_W-1:0];
            end
        end
        else if (i_paddr == `ACMP_STAT0_OFS)
        begin
            rdata = {29'h0, 1'b0, res_r[0], 1'b0};
        end
        else if (i_paddr == `ACMP_STAT1_OFS)
        begin
            rdata = {29'h0, 1'b0, res_r[1], 1'b0};
        end
        else if (i_paddr == `ACMP_STAT2_OFS)
        begin
            rdata = {29'h0, 1'b0, res_r[2], 1'b0};
        end
        else if (i_paddr == `ACMP_CTL0_OFS)
        begin
            rdata = {20'h0, ctl_r[0]};
            if (done && i_pwrite)
            begin
                ctl_nxt[0] = i_pwdata[`ACMP_CTL_W-1:0];
            end
        end
        else if (i_paddr == `ACMP_CTL1_OFS)
        begin
            rdata = {20'h0, ctl_r[1]};
            if (done && i_pwrite)
            begin
                ctl_nxt[1] = i_pwdata[`ACMP_CTL_W-1:0];
            end
        end
        else if (i_paddr == `ACMP_CTL2_OFS)
        begin
            rdata = {20'h0, ctl_r[2]};
            if (done && i_pwrite)
            begin
                ctl_nxt[2] = i_pwdata[`ACMP_CTL_W-1:0];
            end
        end
        else
        begin
            hit = 1'b0; // unmapped: zero data, error
        end
        // read data and error are captured in the wait cycle
        prdata_nxt = (pready_nxt && !i_pwrite) ? rdata : `ACMP_RST_WORD;
        pslverr_nxt = pready_nxt & ~hit;
        // sticky raw bits, a new event beats a clear
        raw_nxt = ev | (raw_r & ~clr);
        irq_nxt = |(raw_nxt & inten_nxt);
        // polarity, then the same result feeds pin and status
        for (int i = 0; i < 3; i++)
        begin
            res_nxt[i] = sync2_r[i] ^ ctl_nxt[i][`ACMP_CTL_INV];
            conn_nxt[i] = src_legal(i,
                ctl_nxt[i][`ACMP_CTL_SRC_HI:`ACMP_CTL_SRC_LO]);
        end
        // ladder: ground unless enabled, offset in low range
        units_nxt = ref_nxt[`ACMP_REF_RNG] ? `ACMP_LADDER_HIGH_UNITS
                                           : `ACMP_LADDER_LOW_UNITS;
        if (!ref_nxt[`ACMP_REF_EN])
        begin
            tap_nxt = `ACMP_TAP_GROUND;
        end
        else if (ref_nxt[`ACMP_REF_RNG])
        begin
            tap_nxt = {2'h0, ref_nxt[`ACMP_REF_TAP_HI:`ACMP_REF_TAP_LO]};
        end
        else
        begin
            tap_nxt = {2'h0, ref_nxt[`ACMP_REF_TAP_HI:`ACMP_REF_TAP_LO]}
                      + `ACMP_LADDER_OFFSET;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // the synchroniser runs on through reset so the path settles
    always_ff @(posedge i_clk)
    begin
        sync1_r <= i_compare_result;
        sync2_r <= sync1_r;
        // result and its edge history run on as well, so they leave
        // reset at the pin level and raise no false event after it
        res_r <= res_nxt;
        prev_r <= res_r;
        if (!i_resetn)
        begin
            for (int i = 0; i < 3; i++)
            begin
                ctl_r[i] <= `ACMP_RST_CTL;
            end
            ref_r <= `ACMP_RST_REF;
            inten_r <= `ACMP_RST_BITS;
            raw_r <= `ACMP_RST_BITS;
            conn_r <= `ACMP_RST_CONN;
            tap_r <= `ACMP_TAP_GROUND;
            units_r <= `ACMP_LADDER_LOW_UNITS;
            irq_r <= 1'b0;
            prdata_r <= `ACMP_RST_WORD;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            ctl_r <= ctl_nxt;
            ref_r <= ref_nxt;
            inten_r <= inten_nxt;
            raw_r <= raw_nxt;
            conn_r <= conn_nxt;
            tap_r <= tap_nxt;
            units_r <= units_nxt;
            irq_r <= irq_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------
    // negative inputs stay hard wired to their own pins
    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    assign o_comp0_positive_source_select =
        ctl_r[0][`ACMP_CTL_SRC_HI:`ACMP_CTL_SRC_LO];
    assign o_comp1_positive_source_select =
        ctl_r[1][`ACMP_CTL_SRC_HI:`ACMP_CTL_SRC_LO];
    assign o_comp2_positive_source_select =
        ctl_r[2][`ACMP_CTL_SRC_HI:`ACMP_CTL_SRC_LO];
    assign o_positive_connect = conn_r;
    assign o_ladder_enable = ref_r[`ACMP_REF_EN];
    assign o_ladder_range_select = ref_r[`ACMP_REF_RNG];
    assign o_ladder_total_units = units_r;
    assign o_ladder_tap_pos = tap_r;
    // pin path never looks at interrupt state
    assign o_comp0_output_pin_o = res_r[0];
    // software must not drive this while comp1 reads the pin
    assign o_comp0_output_pin_oe = ctl_r[0][`ACMP_CTL_PIN_EN];
    assign o_irq = irq_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    sequence s_held0;
        $stable(i_compare_result[0])[*4];
    endsequence
    sequence s_ctl0_quiet;
        $stable(ctl_r[0])[*4];
    endsequence

    a_pready_one_wait: assert property (
        access && !pready_r |=> pready_r ##1 !pready_r)
        else $error("pready not one cycle after access");
    a_unmapped_error: assert property (
        access && !pready_r && !hit |=> pslverr_r && pready_r)
        else $error("unmapped address without error");
    a_result_follow: assert property (
        s_held0 and s_ctl0_quiet |->
        res_r[0] == (i_compare_result[0] ^ ctl_r[0][`ACMP_CTL_INV]))
        else $error("result bit does not follow input");
    a_w1c_clear: assert property (
        done && i_pwrite && i_paddr == `ACMP_MIS_OFS && i_pwdata[0]
        |=> !raw_r[0] || $past(ev[0]))
        else $error("masked write one did not clear");
    a_raw_sticky: assert property (
        raw_r[1] && !clr[1] |=> raw_r[1])
        else $error("raw bit lost without clear");
    a_irq_masked: assert property (
        ##1 irq_r == |(raw_r & inten_r))
        else $error("irq not OR of masked bits");
    a_tap_low_range: assert property (
        ref_r[`ACMP_REF_EN] && !ref_r[`ACMP_REF_RNG] |->
        tap_r == {2'h0, ref_r[`ACMP_REF_TAP_HI:`ACMP_REF_TAP_LO]}
                 + `ACMP_LADDER_OFFSET
        && units_r == `ACMP_LADDER_LOW_UNITS)
        else $error("low range tap wrong");
    a_tap_ground: assert property (
        !ref_r[`ACMP_REF_EN] |-> tap_r == `ACMP_TAP_GROUND)
        else $error("disabled ladder not ground");
    a_reserved_quiet: assert property (
        !conn_r[2] && !raw_r[2] |=> !raw_r[2])
        else $error("reserved source raised interrupt");
endmodule

//--- acmp_analog_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// comparator cores, reference ladder and shared pin
// ----------------------------------------------------------
module acmp_analog_model
(
    // analog levels in millivolts from the bench
    input var int i_pos_mv [3],
    input var int i_neg_mv [3],
    // mux and ladder controls from the block
    input wire logic [1:0] i_sel0,
    input wire logic [1:0] i_sel1,
    input wire logic [1:0] i_sel2,
    input wire logic [2:0] i_connect,
    input wire logic i_ladder_enable,
    input wire logic [5:0] i_total_units,
    input wire logic [5:0] i_tap_pos,
    // shared pin driver from the block
    input wire logic i_pin_o,
    input wire logic i_pin_oe,
    // digital results, no hysteresis modelled
    output logic [2:0] o_result
);
    int ref_mv; // ladder tap level
    int pin_mv; // level seen on the shared pin
    int vp [3]; // positive input per core
    // ideal cores: settle at once, the block adds its own sync delay
    always_comb
    begin
        // disabled ladder is ground whatever the tap says
        ref_mv = 0;
        if (i_ladder_enable && i_total_units != 6'h00)
            ref_mv = (3300 * i_tap_pos) / i_total_units;
        // a driven pin shows the driver, else the bench level
        pin_mv = i_pin_oe ? (i_pin_o ? 3300 : 0) : i_pos_mv[1];
        vp[0] = (i_sel0 == 2'h2) ? ref_mv : i_pos_mv[0];
        vp[1] = (i_sel1 == 2'h0) ? pin_mv : i_pos_mv[0];
        vp[2] = (i_sel2 == 2'h0) ? i_pos_mv[2] : i_pos_mv[0];
        // negative side is the own pin; an open input reads low
        for (int k = 0; k < 3; k++)
            o_result[k] = i_connect[k] && (vp[k] > i_neg_mv[k]);
    end
endmodule

//--- analog_comparator_control_bench.sv
`timescale 1ns/1ps
`include "acmp_regs.svh"
module analog_comparator_control_bench;
    // ------------------------------------------------------
    // signals
    // ------------------------------------------------------
    logic clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] result, connect;
    logic [1:0] sel [3]; // source code per comparator
    logic len, lrng, pin_o, pin_oe, irq;
    logic [5:0] units, tap;
    int pos_mv [3]; // positive pin levels, middle is the shared pin
    int neg_mv [3]; // negative pin levels
    int failures = 0;
    int check_count = 0;
    always #50 clk = ~clk;
    acmp_ctrl dut (.i_clk(clk), .i_resetn(resetn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_compare_result(result),
        .o_comp0_positive_source_select(sel[0]),
        .o_comp1_positive_source_select(sel[1]),
        .o_comp2_positive_source_select(sel[2]),
        .o_positive_connect(connect), .o_ladder_enable(len),
        .o_ladder_range_select(lrng), .o_ladder_total_units(units),
        .o_ladder_tap_pos(tap), .o_comp0_output_pin_o(pin_o),
        .o_comp0_output_pin_oe(pin_oe), .o_irq(irq));
    acmp_analog_model model (.i_pos_mv(pos_mv), .i_neg_mv(neg_mv),
        .i_sel0(sel[0]), .i_sel1(sel[1]), .i_sel2(sel[2]),
        .i_connect(connect), .i_ladder_enable(len),
        .i_total_units(units), .i_tap_pos(tap), .i_pin_o(pin_o),
        .i_pin_oe(pin_oe), .o_result(result));
    // ------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr_en, input logic [11:0] addr,
                       input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // bounded wait, the slave decides the latency
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            failures++;
            print_verdict();
        end
        // idle edge so the next setup never lands in this time step
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask
    // ------------------------------------------------------
    // scenarios
    // ------------------------------------------------------
    task automatic test_reset;
        logic [11:0] ofs [7] = '{`ACMP_MIS_OFS, `ACMP_RIS_OFS,
            `ACMP_INTEN_OFS, `ACMP_REFCTL_OFS, `ACMP_CTL0_OFS,
            `ACMP_CTL1_OFS, `ACMP_CTL2_OFS};
        logic [31:0] r;
        logic e;
        foreach (ofs[i])
        begin
            rd(ofs[i], r);
            check("reset value", r, 32'h0);
        end
        check("reset connect", {29'h0, connect}, 32'h7);
        apb(1'b0, 12'h00c, 32'h0, r, e);
        check("unmapped error", {31'h0, e}, 32'h1);
        check("unmapped data", r, 32'h0);
        wr(`ACMP_RIS_OFS, 32'hffff_ffff);
        rd(`ACMP_RIS_OFS, r);
        check("raw read only", r, 32'h0);
        wr(`ACMP_INTEN_OFS, 32'hffff_ffff);
        rd(`ACMP_INTEN_OFS, r);
        check("enable bits", r, 32'h7);
        wr(`ACMP_INTEN_OFS, 32'h0);
    endtask
    task automatic test_ladder;
        logic [31:0] w [3] = '{32'h30c, 32'h20c, 32'h10c};
        logic [5:0] u [3] = '{6'h18, 6'h20, 6'h18};
        logic [5:0] t [3] = '{6'h0c, 6'h14, 6'h00};
        logic [31:0] r;
        for (int i = 0; i < 3; i++)
        begin
            wr(`ACMP_REFCTL_OFS, w[i]);
            repeat (2) @(posedge clk);
            check("ladder units", 32'(units), 32'(u[i]));
            check("ladder tap", 32'(tap), 32'(t[i]));
            check("ladder en", 32'(len), 32'(w[i][`ACMP_REF_EN]));
            check("ladder rng", 32'(lrng), 32'(w[i][`ACMP_REF_RNG]));
            rd(`ACMP_REFCTL_OFS, r);
            check("ladder word", r, w[i]);
        end
        // leave the ladder at range 1, tap 12
        wr(`ACMP_REFCTL_OFS, 32'h30c);
    endtask
    // every source code of every comparator, rising sense
    task automatic test_sources;
        logic [3:0] res_m [3] = '{4'b0011, 4'b0010, 4'b0010};
        logic [3:0] con_m [3] = '{4'b0111, 4'b0011, 4'b0011};
        logic [31:0] r;
        neg_mv <= '{1800, 1000, 1800};
        for (int n = 0; n < 3; n++)
            for (int c = 0; c < 4; c++)
            begin
                wr(12'h024 + 12'(n * 32), {21'h0, 2'(c), 9'h008});
                // settling wait before the result is read
                repeat (6) @(posedge clk);
                check("source code", {30'h0, sel[n]}, c);
                check("connect", 32'(connect[n]), 32'(con_m[n][c]));
                rd(12'h020 + 12'(n * 32), r);
                check("result bit", r, {30'h0, res_m[n][c], 1'b0});
            end
    endtask
    task automatic test_irq;
        logic [31:0] r;
        wr(`ACMP_CTL0_OFS, 32'h008);
        wr(`ACMP_CTL2_OFS, 32'h008);
        neg_mv <= '{2500, 1000, 2500};
        repeat (6) @(posedge clk);
        wr(`ACMP_MIS_OFS, 32'h7);
        rd(`ACMP_RIS_OFS, r);
        check("raw cleared", r, 32'h0);
        wr(`ACMP_INTEN_OFS, 32'h1);
        neg_mv <= '{500, 1000, 500};
        repeat (6) @(posedge clk);
        rd(`ACMP_RIS_OFS, r);
        check("raw set", r, 32'h5);
        rd(`ACMP_MIS_OFS, r);
        check("masked", r, 32'h1);
        check("irq high", {31'h0, irq}, 32'h1);
        wr(`ACMP_MIS_OFS, 32'h0);
        rd(`ACMP_RIS_OFS, r);
        check("write zero", r, 32'h5);
        wr(`ACMP_MIS_OFS, 32'h1);
        rd(`ACMP_RIS_OFS, r);
        check("clear one", r, 32'h4);
        check("irq low", {31'h0, irq}, 32'h0);
        wr(`ACMP_INTEN_OFS, 32'h4);
        check("irq comp2", {31'h0, irq}, 32'h1);
        wr(`ACMP_MIS_OFS, 32'h4);
        check("irq cleared", {31'h0, irq}, 32'h0);
    endtask
    // pin drive does not disturb the interrupt side
    task automatic test_pin;
        logic [31:0] r;
        wr(`ACMP_CTL0_OFS, 32'h800);
        repeat (6) @(posedge clk);
        check("pin enable", {31'h0, pin_oe}, 32'h1);
        check("pin level", {31'h0, pin_o}, 32'h1);
        wr(`ACMP_CTL0_OFS, 32'h802);
        repeat (6) @(posedge clk);
        check("pin inverted", {31'h0, pin_o}, 32'h0);
        rd(`ACMP_STAT0_OFS, r);
        check("status inverted", r, 32'h0);
        check("irq untouched", {31'h0, irq}, 32'h0);
    endtask
    // level high, falling edge and both-edge sense modes
    task automatic test_sense;
        logic [31:0] r;
        wr(`ACMP_CTL0_OFS, 32'h010);
        wr(`ACMP_CTL2_OFS, 32'h004);
        repeat (6) @(posedge clk);
        wr(`ACMP_MIS_OFS, 32'h7);
        rd(`ACMP_RIS_OFS, r);
        check("level high", r, 32'h1);
        neg_mv <= '{500, 1000, 2500};
        repeat (6) @(posedge clk);
        rd(`ACMP_RIS_OFS, r);
        check("fall edge", r, 32'h5);
        wr(`ACMP_CTL2_OFS, 32'h00c);
        wr(`ACMP_MIS_OFS, 32'h4);
        rd(`ACMP_RIS_OFS, r);
        check("both quiet", r, 32'h1);
        neg_mv <= '{500, 1000, 500};
        repeat (6) @(posedge clk);
        rd(`ACMP_RIS_OFS, r);
        check("both edges", r, 32'h5);
    endtask
    // ------------------------------------------------------
    // main sequence
    // ------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        // all results high at reset so no level event fires
        pos_mv = '{2000, 500, 1500};
        neg_mv = '{100, 100, 100};
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        test_reset();
        test_ladder();
        test_sources();
        test_irq();
        test_pin();
        test_sense();
        print_verdict();
    end
endmodule
